// [cipher_rekey_pkg.sv]
/*
 * Constants, states and message codes for the portable-side cipher
 * re-key and handover sequencer. Assumes a 10 MHz system clock and a
 * frame strobe from the slot timer outside this block.
 */
// Overview of operation
// - derived re-key: stop exchange, then start with the new key on confirm
// - default re-key uses same stop-then-start with default variants and index
// - selecting a default key index also selects its tied algorithm
// - fixed-side default request: start re-key next frame or ignore it
// - obey fixed-side request only when a handover case permits it
// - wait after a default start request resets the retry counter
// - switching not done within one second: release and disconnect
// - hold user and signalling data while a wait-extended switch runs; the code holds user data only (hold_user_data)
// - new bearer takes the current mode, cipher key and init value
// - both handover connections use the same keystream pair per frame
// - second connection starts clear; release first only once encrypted
// - external handover: new leg clear; cipher only after old leg clear
// - request sent from next even frame, five even frames or until confirm
// - grant in next even frame after start confirm; encrypt from grant
// - no confirm after the retries: release and raise disconnect
package cipher_rekey_pkg;
	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned SWITCH_LIMIT_MS = 1000;
	localparam int unsigned SWITCH_CYCLES   = CLK_HZ / 1000 * SWITCH_LIMIT_MS;
	localparam logic [2:0]  REQ_TRIES       = 3'h5;
	localparam int unsigned KEY_IDX_W       = 8;
	localparam int unsigned ALG_W           = 4;
	localparam int unsigned FRAME_W         = 4;

	// outgoing message codes
	typedef enum logic [2:0] {
		msg_none      = 3'h0,
		msg_start_req = 3'h1,
		msg_start_grt = 3'h2,
		msg_stop_req  = 3'h3,
		msg_stop_grt  = 3'h4
	} tx_msg_e;

	typedef enum logic [6:0] {
		st_idle      = 7'h01,
		st_stop_req  = 7'h02,
		st_stop_grt  = 7'h04,
		st_start_req = 7'h08,
		st_start_grt = 7'h10,
		st_release   = 7'h20,
		st_armed     = 7'h40
	} seq_state_e;
endpackage

// [cipher_rekey_handover_ctrl.sv]
/*
 * Portable-side encryption switching sequencer: start, stop, re-key to a
 * derived or default key, wait handling, timeout and handover gating.
 * Assumes frame_tick pulses once per frame and rx_* pulses coincide with it.
 */
`timescale 1ns/10ps
module cipher_rekey_handover_ctrl
	import cipher_rekey_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = SWITCH_CYCLES
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// frame timing
	input  wire logic                 frame_tick,
	// upper layer commands
	input  wire logic                 cmd_start,
	input  wire logic                 cmd_stop,
	input  wire logic                 cmd_rekey,
	input  wire logic                 cmd_use_default,
	input  wire logic [KEY_IDX_W-1:0] cmd_key_idx,
	input  wire logic                 handover_permit,
	input  wire logic                 old_leg_clear,
	// default and derived key algorithm table results
	input  wire logic [ALG_W-1:0]     default_alg,
	input  wire logic [ALG_W-1:0]     derived_alg,
	// received messages from fixed side
	input  wire logic                 rx_start_conf,
	input  wire logic                 rx_stop_conf,
	input  wire logic                 rx_start_reject,
	input  wire logic                 rx_wait,
	input  wire logic                 rx_fixed_default_req,
	input  wire logic [KEY_IDX_W-1:0] rx_key_idx,
	// transmit message
	output logic [2:0]                tx_msg,
	output logic                      tx_msg_default,
	output logic [KEY_IDX_W-1:0]      tx_key_idx,
	// cipher status
	output logic                      tx_encrypt,
	output logic                      rx_decrypt,
	output logic [ALG_W-1:0]          active_alg,
	output logic                      hold_user_data,
	output logic                      first_leg_release_ok,
	output logic                      bearer_cipher_on,
	output logic                      switch_done,
	output logic                      disconnect_indication
);

	typedef struct packed {
		seq_state_e           st;
		logic [FRAME_W-1:0]   frame;
		logic [2:0]           tries;
		logic                 rekey;
		logic                 use_def;
		logic [KEY_IDX_W-1:0] key_idx;
		logic [ALG_W-1:0]     alg;
		logic                 enc;
		logic                 dec;
		logic                 waited;
		logic                 last_def_req;
		logic [23:0]          timer;
		logic [2:0]           msg;
		logic                 msg_def;
		logic                 done;
		logic                 disc;
	} state_s;

	state_s r;
	state_s next_r;

	logic even_tick;
	logic busy;
	logic timed_out;

	// lsb set now means the frame just starting is even
	assign even_tick = frame_tick && r.frame[0];
	assign busy      = (r.st != st_idle) && (r.st != st_release);
	assign timed_out = busy && (r.timer >= 24'(TIMEOUT_CYCLES - 1));

	// sequencing of the stop/start exchanges
	always_comb begin
		next_r      = r;
		next_r.done = 1'b0;
		next_r.disc = 1'b0;
		if (frame_tick) begin
			next_r.frame = r.frame + 1'b1;
			next_r.msg   = 3'(msg_none);
			next_r.last_def_req = 1'b0;
		end
		if (busy)
			next_r.timer = r.timer + 24'h0001;
		unique case (r.st)
			st_idle: begin
				next_r.timer = 24'h0000;
				next_r.tries = 3'h0;
				next_r.waited = 1'b0;
				// new leg stays clear until the old one is clear
				if (cmd_start && !r.enc && old_leg_clear) begin
					next_r.st      = st_armed;
					next_r.use_def = cmd_use_default;
					next_r.key_idx = cmd_key_idx;
					next_r.rekey   = 1'b0;
				end else if ((cmd_stop || cmd_rekey) && r.enc) begin
					next_r.st      = st_stop_req;
					next_r.rekey   = cmd_rekey;
					next_r.use_def = cmd_use_default;
					next_r.key_idx = cmd_key_idx;
				end else if (rx_fixed_default_req && r.enc
					&& handover_permit) begin
					next_r.st      = st_stop_req;
					next_r.rekey   = 1'b1;
					next_r.use_def = 1'b1;
					next_r.key_idx = rx_key_idx;
				end
			end
			st_armed: begin
				// first request goes out in the next even frame
				if (even_tick) begin
					next_r.st    = st_start_req;
					next_r.msg   = 3'(msg_start_req);
					next_r.msg_def = r.use_def;
					next_r.last_def_req = r.use_def;
					next_r.tries = 3'h1;
				end
			end
			st_stop_req: begin
				if (rx_stop_conf) begin
					next_r.dec = 1'b0;
					next_r.st  = st_stop_grt;
				end else if (even_tick) begin
					if (r.tries == REQ_TRIES)
						next_r.st = st_release;
					else begin
						next_r.msg   = 3'(msg_stop_req);
						next_r.tries = r.tries + 3'h1;
					end
				end
			end
			st_stop_grt: begin
				if (even_tick) begin
					next_r.msg   = 3'(msg_stop_grt);
					next_r.enc   = 1'b0;
					// restart gets a full five start requests of its own
					next_r.tries = 3'h0;
					if (r.rekey) begin
						// restart at once with the new key
						next_r.st    = st_start_req;
						next_r.msg_def = r.use_def;
						next_r.last_def_req = r.use_def;
					end else begin
						next_r.st   = st_idle;
						next_r.done = 1'b1;
					end
				end
			end
			st_start_req: begin
				if (rx_wait && r.last_def_req && r.use_def) begin
					next_r.tries  = 3'h0;
					next_r.waited = 1'b1;
				end else if (rx_start_conf) begin
					next_r.dec = 1'b1;
					next_r.alg = r.use_def ? default_alg : derived_alg;
					next_r.st  = st_start_grt;
				end else if (rx_start_reject && r.use_def) begin
					next_r.st   = st_idle;
					next_r.done = 1'b1;
				end else if (even_tick) begin
					if (r.tries == REQ_TRIES)
						next_r.st = st_release;
					else begin
						next_r.msg   = 3'(msg_start_req);
						next_r.msg_def = r.use_def;
						next_r.last_def_req = r.use_def;
						next_r.tries = r.tries + 3'h1;
					end
				end
			end
			st_start_grt: begin
				if (even_tick) begin
					next_r.msg  = 3'(msg_start_grt);
					next_r.enc  = 1'b1;
					next_r.st   = st_idle;
					next_r.done = 1'b1;
				end
			end
			st_release: begin
				next_r.enc  = 1'b0;
				next_r.dec  = 1'b0;
				next_r.disc = 1'b1;
				if (!cmd_start && !cmd_rekey)
					next_r.st = st_idle;
				else
					next_r.disc = 1'b0;
			end
		endcase
		if (timed_out) begin
			next_r.st   = st_release;
			next_r.disc = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r       <= '0;
			r.st    <= st_idle;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from state flops
	assign tx_msg         = r.msg;
	assign tx_msg_default = r.msg_def;
	assign tx_key_idx     = r.key_idx;
	assign tx_encrypt     = r.enc;
	assign rx_decrypt     = r.dec;
	assign active_alg     = r.alg;
	// new bearer copies this leg's mode; key and iv stay shared
	assign bearer_cipher_on = r.enc;
	// keep data back after a wait until the switch lands
	assign hold_user_data = r.waited && busy;
	assign first_leg_release_ok = r.enc && (r.st == st_idle);
	assign switch_done    = r.done;
	assign disconnect_indication = r.disc || (timed_out && 1'b1);

	// grant is sent exactly one even frame after start confirm
	sequence s_conf_seen;
		(r.st == st_start_req) && rx_start_conf && !rx_wait
		&& !timed_out;
	endsequence
	sequence s_grant_edge;
		(r.st == st_start_grt) && even_tick && !timed_out;
	endsequence
	property p_grant_follows;
		@(posedge clk) disable iff (!rst_n)
		s_conf_seen |=> (r.st == st_start_grt);
	endproperty
	property p_grant_sent;
		@(posedge clk) disable iff (!rst_n)
		s_grant_edge
		|=> tx_encrypt && (tx_msg == 3'(msg_start_grt));
	endproperty
	a_grant_after_conf: assert property (p_grant_follows)
		else $error("grant state not entered after start confirm");

	a_grant_on_even: assert property (p_grant_sent)
		else $error("grant not sent in even frame");

	// stop grant goes out first, the start request one even frame later
	a_stop_then_start: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == st_stop_grt) && even_tick && r.rekey && !timed_out
		|=> (tx_msg == 3'(msg_stop_grt)) && (r.st == st_start_req)
		&& !tx_encrypt)
		else $error("restart did not follow stop grant");

	a_retry_limit: assert property (@(posedge clk) disable iff (!rst_n)
		busy |-> r.tries <= REQ_TRIES)
		else $error("request retries exceeded five");

	a_release_disc: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == st_start_req) && even_tick && r.tries == REQ_TRIES
		&& !rx_start_conf && !rx_wait && !rx_start_reject && !timed_out
		|=> ##1 disconnect_indication)
		else $error("no disconnect after exhausted retries");

	a_timeout_disc: assert property (@(posedge clk) disable iff (!rst_n)
		timed_out |-> disconnect_indication ##1 (r.st == st_release))
		else $error("timeout did not release");

	a_ignore_fixed: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == st_idle) && rx_fixed_default_req && !handover_permit
		&& !cmd_start && !cmd_stop && !cmd_rekey
		|=> r.st == st_idle)
		else $error("fixed side request obeyed without permit");

	a_wait_reset: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == st_start_req) && rx_wait && r.last_def_req && r.use_def
		&& !timed_out |=> r.tries == 3'h0 && hold_user_data)
		else $error("wait did not reset retries");

	a_alg_default: assert property (@(posedge clk) disable iff (!rst_n)
		s_conf_seen ##0 r.use_def
		|=> active_alg == $past(default_alg))
		else $error("default key algorithm not selected");

	a_even_first_req: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == st_armed) && even_tick && !timed_out
		|=> tx_msg == 3'(msg_start_req))
		else $error("first request not in even frame");

endmodule // cipher_rekey_handover_ctrl

// [fixed_side_model.sv]
/* fixed side model: frame timer, answers, waits and default re-key requests.
   assumes the sequencer's tx_* outputs are registered and stand a frame. */
`timescale 1ns/10ps
module fixed_side_model
	import cipher_rekey_pkg::*;
#(
	parameter int unsigned FRAME_CYCLES = 8
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// behaviour controls
	input  wire logic                 answer,
	input  wire logic                 reject,
	input  wire logic                 stall,
	input  wire logic                 fd_req,
	input  wire logic [KEY_IDX_W-1:0] fd_idx,
	// portable side messages
	input  wire logic [2:0]           tx_msg,
	input  wire logic                 tx_msg_default,
	// towards the sequencer
	output logic                      frame_tick,
	output logic                      rx_start_conf,
	output logic                      rx_stop_conf,
	output logic                      rx_start_reject,
	output logic                      rx_wait,
	output logic                      rx_fixed_default_req,
	output logic [KEY_IDX_W-1:0]      rx_key_idx
);
	int unsigned cyc;
	logic        fcnt;
	logic [2:0]  sends;
	logic        odd;
	logic        start_seen;
	logic        fd_now;
	// odd frame opens at a tick whose counter lsb is still 0
	assign odd = frame_tick & ~fcnt;
	assign start_seen = odd & (tx_msg == msg_start_req);
	assign fd_now = odd & fd_req & (sends < 3'h6) & (tx_msg != msg_stop_req);
	// answers only in the odd frame after a request
	assign rx_start_conf = start_seen & answer & ~reject & ~stall;
	assign rx_start_reject = start_seen & reject & tx_msg_default;
	assign rx_wait = start_seen & stall & tx_msg_default;
	assign rx_stop_conf = odd & answer & (tx_msg == msg_stop_req);
	assign rx_fixed_default_req = fd_now;
	// index only means something with the request, so invert it otherwise
	assign rx_key_idx = fd_now ? fd_idx : ~fd_idx;
	// frame timer; request repeats at most six odd frames, up to 2S+11
	always @(posedge clk) begin
		if (!rst_n) begin
			cyc <= 0;
			frame_tick <= 1'b0;
			fcnt <= 1'b0;
			sends <= 3'h0;
		end else begin
			cyc <= (cyc == FRAME_CYCLES - 1) ? 0 : cyc + 1;
			frame_tick <= (cyc == FRAME_CYCLES - 1);
			fcnt <= fcnt ^ frame_tick;
			if (!fd_req) sends <= 3'h0;
			else if (tx_msg == msg_stop_req) sends <= 3'h6;
			else if (fd_now) sends <= sends + 3'h1;
		end
	end
endmodule // fixed_side_model

// [test_cipher_rekey_handover_ctrl.sv]
/* bench for the cipher re-key sequencer against the fixed side model.
   assumes 100 ns clock and an eight cycle frame from the model. */
`timescale 1ns/10ps
module test_cipher_rekey_handover_ctrl;
	import cipher_rekey_pkg::*;
	localparam int unsigned TO = 2000;
	logic clk, rst_n, frame_tick, cmd_start, cmd_stop, cmd_rekey;
	logic cmd_use_default, handover_permit, old_leg_clear, answer, reject;
	logic stall, fd_req, rx_start_conf, rx_stop_conf, rx_start_reject;
	logic rx_wait, rx_fixed_default_req, tx_msg_default, tx_encrypt;
	logic rx_decrypt, hold_user_data, first_leg_release_ok;
	logic bearer_cipher_on, switch_done, disconnect_indication, ev, fc, dq;
	logic skip;
	logic [7:0] cmd_key_idx, rx_key_idx, tx_key_idx, fd_idx, k;
	logic [3:0] default_alg, derived_alg, active_alg;
	logic [2:0] tx_msg;
	logic [11:0] q[$];
	int n_fail, n_checks, n_tx, n_done, n_dis, cyc, c0, t0;
	cipher_rekey_handover_ctrl #(.TIMEOUT_CYCLES(TO)) DUT (.*);
	fixed_side_model #(.FRAME_CYCLES(8)) fs (.*);
	// clock and watchdog
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 9000) begin
			fail("watchdog");
			summarize;
		end
	end
	task fail(input string s);
		n_fail++;
		$display("unexpected at %0t: %s", $time, s);
	endtask
	task chk(input bit ok, input string s);
		n_checks++;
		if (!ok) fail(s);
	endtask
	task summarize;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// compare a result with the oldest note; extras only on start messages
	task note(input logic [11:0] g);
		logic [11:0] e;
		n_tx++;
		if (!skip) begin
			if (q.size() == 0) fail("result with no note");
			else begin
				e = q.pop_front();
				n_checks++;
				if (g[11:9] !== e[11:9] || (e[11:9] inside {3'h1, 3'h2} &&
					(g[8] !== e[8] || (e[8] && g[7:0] !== e[7:0]))))
					fail("wrong message");
			end
		end
	endtask
	task exp(input logic [2:0] m, input logic d, input logic [7:0] i);
		q.push_back({m, d, i});
	endtask
	// even frame tracker: message sampled after each even tick
	always @(posedge clk) begin
		ev <= frame_tick & fc;
		fc <= !rst_n ? 1'b0 : fc ^ frame_tick;
	end
	always @(negedge clk) begin
		if (rst_n && ev && tx_msg !== msg_none)
			note({tx_msg, tx_msg_default, tx_key_idx});
		if (rst_n && disconnect_indication === 1'b1 && !dq) begin
			n_dis++;
			note({3'h7, 9'h000});
		end
		dq <= disconnect_indication === 1'b1;
		if (rst_n && switch_done === 1'b1) n_done++;
	end
	task frames(input int n);
		repeat (n) @(posedge clk iff frame_tick);
	endtask
	task cmd(input logic s, p, r, d, input logic [7:0] i);
		@(posedge clk);
		{cmd_start, cmd_stop, cmd_rekey, cmd_use_default} <= {s, p, r, d};
		cmd_key_idx <= i;
		@(posedge clk);
		{cmd_start, cmd_stop, cmd_rekey} <= 3'h0;
	endtask
	// wait for all notes to be matched, then close the test
	task drain(input string s);
		for (int i = 0; i < 60 && q.size() != 0; i++) frames(1);
		frames(2);
		chk(q.size() == 0, "notes left over");
		$display("test %s done", s);
	endtask
	initial begin
		{rst_n, cmd_start, cmd_stop, cmd_rekey, cmd_use_default} = 0;
		{handover_permit, reject, stall, fd_req, skip, dq} = 0;
		{old_leg_clear, answer} = 2'b11;
		{cmd_key_idx, fd_idx, default_alg, derived_alg} = 0;
		void'($urandom(78426));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		derived_alg <= 4'($urandom);
		old_leg_clear <= 1'b0;
		cmd(1, 0, 0, 0, 8'h00);
		frames(6);
		chk(n_tx == 0, "start taken with old leg live");
		old_leg_clear <= 1'b1;
		exp(msg_start_req, 0, 0);
		exp(msg_start_grt, 0, 0);
		cmd(1, 0, 0, 0, 8'h00);
		drain("start");
		chk(tx_encrypt === 1'b1 && active_alg === derived_alg, "enc");
		chk(bearer_cipher_on === 1'b1, "bearer mode");
		chk(first_leg_release_ok === 1'b1, "release ok");
		chk(n_done == 1, "done pulse");
		q.delete();
		exp(msg_stop_req, 0, 0);
		exp(msg_stop_grt, 0, 0);
		exp(msg_start_req, 0, 0);
		exp(msg_start_grt, 0, 0);
		cmd(0, 0, 1, 0, 8'h00);
		drain("rekey");
		k = 8'($urandom);
		fd_idx <= k;
		default_alg <= 4'($urandom);
		c0 = n_tx;
		fd_req <= 1'b1;
		frames(16);
		fd_req <= 1'b0;
		chk(n_tx == c0, "fixed request obeyed");
		handover_permit <= 1'b1;
		exp(msg_stop_req, 1, k);
		exp(msg_stop_grt, 1, k);
		exp(msg_start_req, 1, k);
		exp(msg_start_grt, 1, k);
		@(posedge clk);
		fd_req <= 1'b1;
		drain("fixed");
		fd_req <= 1'b0;
		chk(active_alg === default_alg && tx_encrypt === 1'b1, "alg");
		exp(msg_stop_req, 0, 0);
		exp(msg_stop_grt, 0, 0);
		cmd(0, 1, 0, 0, 8'h00);
		drain("stop");
		chk(tx_encrypt === 1'b0 && rx_decrypt === 1'b0, "still enc");
		c0 = n_done;
		reject <= 1'b1;
		k = 8'($urandom);
		exp(msg_start_req, 1, k);
		cmd(1, 0, 0, 1, k);
		drain("reject");
		reject <= 1'b0;
		chk(tx_encrypt === 1'b0 && n_done == c0 + 1, "reject");
		stall <= 1'b1;
		skip <= 1'b1;
		c0 = n_tx;
		t0 = cyc;
		cmd(1, 0, 0, 1, k);
		frames(8);
		chk(hold_user_data === 1'b1, "no hold");
		for (int i = 0; i < TO && n_dis == 0; i++) @(posedge clk);
		chk(n_tx - c0 > 6, "retries not extended");
		chk(cyc - t0 > TO - 30 && cyc - t0 < TO + 40, "timeout");
		stall <= 1'b0;
		frames(3);
		skip <= 1'b0;
		$display("test wait done");
		answer <= 1'b0;
		repeat (5) exp(msg_start_req, 0, 0);
		exp(3'h7, 0, 0);
		cmd(1, 0, 0, 0, 8'h00);
		drain("no answer");
		summarize;
	end
endmodule // test_cipher_rekey_handover_ctrl
